/* File: logic/ori_pkg.sv */
// constants, register map and types for the output restart interlock
package ori_pkg;
    // clock and time base
    localparam int CLK_HZ      = 32'h0773_5940;
    localparam int MS_PER_S    = 32'h0000_03E8;
    localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
    // longest restart button actuation, in seconds, and as milliseconds
    localparam int BTN_MAX_S   = 32'h0000_0004;
    localparam int BTN_MAX_MS  = BTN_MAX_S * MS_PER_S;

    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DELAY  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DUST   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OSIZE  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OSPEED = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RESP   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FIELD  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;

    // control register fields
    localparam int CTRL_PU_LSB    = 0;
    localparam int CTRL_RESTART   = 2;
    localparam int CTRL_FACTORY   = 3;
    localparam int CTRL_PRE_LSB   = 4;
    localparam int CTRL_APPLY     = 8;

    // values after reset; a factory reset restores all but the delay
    localparam logic [15:0] RST_DELAY_MS  = 16'h0064;
    localparam logic        RST_DUST_ON   = 1'b1;
    localparam logic [15:0] RST_OSIZE_MM  = 16'h0046;
    localparam logic [15:0] RST_OSPEED    = 16'h0640;
    localparam logic [15:0] RST_RESP_MS   = 16'h0050;
    localparam logic [15:0] RST_FIELD_DEF = 16'h0001;

    // application presettings: index 0 forces nothing
    localparam logic [3:0]  PRE_FREE      = 4'h0;
    localparam logic [3:0]  PRE_OBJECT    = 4'h1;
    localparam logic [3:0]  PRE_FOURFIELD = 4'h2;
    localparam logic [3:0]  PRE_ACCESS    = 4'h3;
    localparam logic [15:0] P4_RESP_MS    = 16'h00A0;
    localparam logic [15:0] P4_FIELD_DEF  = 16'h000F;
    localparam logic [15:0] PA_OSIZE_MM   = 16'h0096;
    localparam logic [15:0] PA_FIELD_DEF  = 16'h0003;

    typedef enum logic [1:0] {
        PU_AUTO      = 2'b00,
        PU_INTERLOCK = 2'b01,
        PU_TEST      = 2'b10
    } ori_pwrup_t;

    typedef enum logic [3:0] {
        ST_BOOT_DLY = 4'b0000,
        ST_WAIT_BTN = 4'b0001,
        ST_TEST_CLR = 4'b0010,
        ST_TEST_ARM = 4'b0011,
        ST_TEST_REL = 4'b0100,
        ST_ON       = 4'b0101,
        ST_OCC      = 4'b0110,
        ST_RST_DLY  = 4'b0111,
        ST_LOCKED   = 4'b1000
    } ori_state_t;
endpackage

/* File: logic/ori_sync.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module ori_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: logic/ori_ms_timer.sv */
// millisecond tick divider and loadable millisecond down counter
`timescale 1ns/1ns
`default_nettype none
module ori_ms_timer
#(
    parameter int CYC_PER_MS = 125000
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] load_ms,
    output var  logic        tick,
    output var  logic        done
);
    localparam int DIV_W = $clog2(CYC_PER_MS);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);

    logic [DIV_W-1:0] div_r;
    logic [15:0]      cnt_r;
    logic             run_r;
    wire              div_wrap = (div_r == DIV_LAST);

    // the divider restarts with the timer so the first millisecond is whole
    always_ff @(posedge clk)
    begin
        if (rst || start)
            div_r <= '0;
        else if (div_wrap)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 16'h0000;
            run_r <= 1'b0;
            done  <= 1'b0;
            tick  <= 1'b0;
        end
        else
        begin
            tick <= div_wrap;
            if (start)
            begin
                cnt_r <= load_ms;
                run_r <= 1'b1;
                done  <= 1'b0;
            end
            else if (run_r && cnt_r == 16'h0000)
            begin
                run_r <= 1'b0;
                done  <= 1'b1;
            end
            else if (run_r && div_wrap)
                cnt_r <= cnt_r - 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: logic/ori_interlock.sv */
// start-up and restart interlock for the two switching outputs
//
// Overview of operation
// - automatic start-up: outputs on after start-up delay, no operator action
// - start interlock: outputs off until restart button, press at most 4 s
// - start-up test: outputs off, near fields must be clear after the delay
// - start-up test: outputs on after near field occupied then cleared
// - restart mode decides how outputs return after a field clears
// - manual restart: interlock engages, outputs off until restart button
// - automatic restart: outputs on after start-up delay once field clears
// - factory reset: dust on, 70 mm, 1600 mm/s, 80 ms
// - selecting a presetting forces its parameters and field definitions
`timescale 1ns/1ns
`default_nettype none
module ori_interlock
    import ori_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS,
    parameter int BTN_LIMIT_MS  = BTN_MAX_MS
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output var  logic [DATA_W-1:0] rdata,
    input  wire logic              field_occupied,
    input  wire logic              near_field_occupied,
    input  wire logic              restart_btn,
    output var  logic              switch_output_a,
    output var  logic              switch_output_b
);
    // configuration registers
    ori_pwrup_t  pwrup_r;
    logic        restart_auto_r;
    logic [3:0]  preset_r;
    logic [15:0] delay_r;
    logic        dust_r;
    logic [15:0] osize_r;
    logic [15:0] ospeed_r;
    logic [15:0] resp_r;
    logic [15:0] field_r;

    ori_state_t  state_r;
    ori_state_t  state_nxt;
    ori_state_t  go_on;

    // restart button
    logic        btn_s;
    logic        btn_d_r;
    logic [15:0] btn_ms_r;
    logic        btn_long_r;

    logic        tick;
    logic        dly_done;
    logic        rst_pulse_r;
    logic        boot_seen_r;
    logic        tmr_start_d_r;

    // bus decode
    wire wr_ctrl   = wr && (addr == OFS_CTRL);
    wire wr_delay  = wr && (addr == OFS_DELAY);
    wire wr_dust   = wr && (addr == OFS_DUST);
    wire wr_osize  = wr && (addr == OFS_OSIZE);
    wire wr_ospeed = wr && (addr == OFS_OSPEED);
    wire wr_resp   = wr && (addr == OFS_RESP);
    wire wr_field  = wr && (addr == OFS_FIELD);

    wire [1:0] pu_wr     = wdata[CTRL_PU_LSB+1:CTRL_PU_LSB];
    // code 2'b11 names no mode, so such a write keeps the old one
    wire       pu_legal  = (pu_wr != 2'b11);
    wire       factory   = wr_ctrl && wdata[CTRL_FACTORY];
    wire [3:0] pre_wr    = wdata[CTRL_PRE_LSB+3:CTRL_PRE_LSB];
    wire       apply     = wr_ctrl && wdata[CTRL_APPLY] && (pre_wr != PRE_FREE);

    // presetting table: what each presetting forces
    wire        pre_obj  = (pre_wr == PRE_OBJECT);
    wire        pre_four = (pre_wr == PRE_FOURFIELD);
    wire        pre_acc  = (pre_wr == PRE_ACCESS);
    wire [15:0] pre_resp = pre_four ? P4_RESP_MS : RST_RESP_MS;
    wire [15:0] pre_size = pre_acc ? PA_OSIZE_MM : RST_OSIZE_MM;
    wire [15:0] pre_fld  = pre_four ? P4_FIELD_DEF :
                           pre_acc  ? PA_FIELD_DEF : RST_FIELD_DEF;
    wire        pre_dust = pre_obj | pre_four | pre_acc;

    // button press is accepted on release, and only if it was short enough
    wire btn_release = btn_d_r && !btn_s;
    wire btn_ok      = btn_release && !btn_long_r;

    // timer is started on every entry into a delayed state
    wire enter_dly = (state_nxt != state_r) && (state_nxt == ST_RST_DLY);
    wire tmr_start = enter_dly || rst_pulse_r;

    // a start into an occupied field lands in the occupied state instead
    assign go_on = field_occupied ? ST_OCC : ST_ON;

    ori_sync u_btn_sync
    (
        .clk  (clk),
        .rst  (rst),
        .din  (restart_btn),
        .dout (btn_s)
    );

    ori_ms_timer
    #(
        .CYC_PER_MS (CYCLES_PER_MS)
    )
    u_timer
    (
        .clk     (clk),
        .rst     (rst),
        .start   (tmr_start),
        .load_ms (delay_r),
        .tick    (tick),
        .done    (dly_done)
    );

    // one pulse after reset release starts the power-up delay
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rst_pulse_r <= 1'b0;
            boot_seen_r <= 1'b0;
        end
        else
        begin
            rst_pulse_r <= !boot_seen_r;
            boot_seen_r <= 1'b1;
        end
    end

    // control register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwrup_r        <= PU_AUTO;
            restart_auto_r <= 1'b0;
            preset_r       <= PRE_FREE;
        end
        else if (wr_ctrl)
        begin
            if (pu_legal)
                pwrup_r <= ori_pwrup_t'(pu_wr);
            restart_auto_r <= wdata[CTRL_RESTART];
            preset_r       <= pre_wr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            delay_r <= RST_DELAY_MS;
        else if (wr_delay)
            delay_r <= wdata[15:0];
    end

    // dust suppression parameters and field definition word
    always_ff @(posedge clk)
    begin
        if (rst || factory)
        begin
            dust_r   <= RST_DUST_ON;
            osize_r  <= RST_OSIZE_MM;
            ospeed_r <= RST_OSPEED;
            resp_r   <= RST_RESP_MS;
            field_r  <= RST_FIELD_DEF;
        end
        else if (apply)
        begin
            dust_r   <= pre_dust;
            osize_r  <= pre_size;
            ospeed_r <= RST_OSPEED;
            resp_r   <= pre_resp;
            field_r  <= pre_fld;
        end
        else
        begin
            if (wr_dust)
                dust_r <= wdata[0];
            if (wr_osize)
                osize_r <= wdata[15:0];
            if (wr_ospeed)
                ospeed_r <= wdata[15:0];
            if (wr_resp)
                resp_r <= wdata[15:0];
            if (wr_field)
                field_r <= wdata[15:0];
        end
    end

    // button hold time in milliseconds, saturating past the limit
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            btn_d_r    <= 1'b0;
            btn_ms_r   <= 16'h0000;
            btn_long_r <= 1'b0;
        end
        else
        begin
            btn_d_r <= btn_s;
            if (!btn_s)
            begin
                btn_ms_r   <= 16'h0000;
                btn_long_r <= 1'b0;
            end
            else if (tick && !btn_long_r)
            begin
                btn_ms_r <= btn_ms_r + 16'h0001;
                if (btn_ms_r >= 16'(BTN_LIMIT_MS))
                    btn_long_r <= 1'b1;
            end
        end
    end

    // sequencing of the outputs
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BOOT_DLY:
                if (dly_done && !rst_pulse_r)
                begin
                    if (pwrup_r == PU_TEST)
                        state_nxt = ST_TEST_CLR;
                    else if (pwrup_r == PU_INTERLOCK)
                        state_nxt = ST_WAIT_BTN;
                    else
                        state_nxt = go_on;
                end
                else if (pwrup_r == PU_INTERLOCK)
                    state_nxt = ST_WAIT_BTN;
            ST_WAIT_BTN:
                if (btn_ok && !field_occupied)
                    state_nxt = ST_ON;
            ST_TEST_CLR:
                if (!near_field_occupied)
                    state_nxt = ST_TEST_ARM;
            ST_TEST_ARM:
                if (near_field_occupied)
                    state_nxt = ST_TEST_REL;
            ST_TEST_REL:
                if (!near_field_occupied)
                    state_nxt = go_on;
            ST_ON:
                if (field_occupied)
                    state_nxt = ST_OCC;
            ST_OCC:
                if (!field_occupied)
                    state_nxt = restart_auto_r ? ST_RST_DLY
                                               : ST_LOCKED;
            ST_RST_DLY:
                if (field_occupied)
                    state_nxt = ST_OCC;
                else if (dly_done && !tmr_start_d_r)
                    state_nxt = ST_ON;
            ST_LOCKED:
                if (field_occupied)
                    state_nxt = ST_OCC;
                else if (btn_ok)
                    state_nxt = ST_ON;
            default:
                state_nxt = ST_OCC;
        endcase
    end

    // done from the previous run is still high in the cycle of a start and low from the next cycle on
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r         <= ST_BOOT_DLY;
            tmr_start_d_r   <= 1'b0;
            switch_output_a <= 1'b0;
            switch_output_b <= 1'b0;
        end
        else
        begin
            state_r         <= state_nxt;
            tmr_start_d_r   <= tmr_start;
            switch_output_a <= (state_nxt == ST_ON);
            switch_output_b <= (state_nxt == ST_ON);
        end
    end

    // read back
    wire [DATA_W-1:0] rd_ctrl = {23'h00_0000, 1'b0, preset_r, 1'b0,
                                 restart_auto_r, pwrup_r};
    wire [DATA_W-1:0] rd_stat = {20'h0_0000, state_r, 1'b0, btn_long_r,
                                 btn_s, near_field_occupied, field_occupied,
                                 dust_r, switch_output_b, switch_output_a};
    wire [DATA_W-1:0] rd_mux =
        (addr == OFS_CTRL)   ? rd_ctrl :
        (addr == OFS_DELAY)  ? {16'h0000, delay_r} :
        (addr == OFS_DUST)   ? {31'h0000_0000, dust_r} :
        (addr == OFS_OSIZE)  ? {16'h0000, osize_r} :
        (addr == OFS_OSPEED) ? {16'h0000, ospeed_r} :
        (addr == OFS_RESP)   ? {16'h0000, resp_r} :
        (addr == OFS_FIELD)  ? {16'h0000, field_r} :
        (addr == OFS_STATUS) ? rd_stat : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 32'h0000_0000;
        else if (rd)
            rdata <= rd_mux;
        else
            rdata <= 32'h0000_0000;
    end
endmodule
`default_nettype wire

/* File: testbench/ori_interlock_asserts.sv */
// port-level assertions for the output restart interlock
`timescale 1ns/1ns
`default_nettype none
module ori_interlock_asserts
    import ori_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS,
    parameter int BTN_LIMIT_MS  = BTN_MAX_MS
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic              field_occupied,
    input  wire logic              near_field_occupied,
    input  wire logic              restart_btn,
    input  wire logic              switch_output_a,
    input  wire logic              switch_output_b
);
    int unsigned held_r;
    // margin covers the synchroniser and the ms tick phase
    wire logic long_w = held_r > (BTN_LIMIT_MS + 1) * CYCLES_PER_MS + 4;

    always_ff @(posedge clk)
    begin
        if (rst || !restart_btn)
            held_r <= 0;
        else
            held_r <= held_r + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_outs_match: assert property (
        switch_output_a == switch_output_b)
        else $error("outputs a and b differ");
    a_occ_off: assert property (
        field_occupied |=> !switch_output_a)
        else $error("outputs stayed on with a field occupied");
    a_rdata_idle: assert property (
        !rd |=> rdata == '0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (
        rd && addr >= 8'h20 |=> rdata == '0)
        else $error("unmapped read gave nonzero data");
    a_reset_quiet: assert property (
        $fell(rst) |-> !switch_output_a [*3])
        else $error("outputs on right after reset");
    a_rise_clear: assert property (
        $rose(switch_output_a) |-> !$past(field_occupied))
        else $error("outputs rose with a field occupied");
    a_status_outs: assert property (
        rd && addr == OFS_STATUS |=> rdata[0] == $past(switch_output_a)
            && rdata[1] == $past(switch_output_b))
        else $error("status read does not show outputs");
    a_long_press: assert property (
        $fell(restart_btn) && long_w |-> !$rose(switch_output_a) [*6])
        else $error("over-long button press enabled outputs");
endmodule

bind ori_interlock ori_interlock_asserts #(
    .CYCLES_PER_MS(CYCLES_PER_MS), .BTN_LIMIT_MS(BTN_LIMIT_MS)
) u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .field_occupied(field_occupied),
    .near_field_occupied(near_field_occupied), .restart_btn(restart_btn),
    .switch_output_a(switch_output_a), .switch_output_b(switch_output_b)
);
`default_nettype wire

/* File: testbench/ori_button_model.sv */
// operator at the restart button pin
`timescale 1ns/1ns
`default_nettype none
module ori_button_model
(
    input  wire logic clk,
    output var  logic restart_btn
);
    initial restart_btn = 1'b0;

    // press length in cycles; the bench chooses over-long presses on purpose
    task automatic press(input int cycles);
        @(posedge clk);
        restart_btn <= 1'b1;
        repeat (cycles) @(posedge clk);
        restart_btn <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the output restart interlock
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import ori_pkg::*;
;
    localparam int CPM = 10;
    localparam int BLM = 20;
    typedef struct packed
    {
        logic        we;
        logic [7:0]  a;
        logic [31:0] d;
    } ori_tb_row_t;
    // writes carry data, reads carry the expected word
    localparam ori_tb_row_t ROWS [0:29] = '{
        '{0, OFS_CTRL, 32'h0}, '{0, OFS_DELAY, 32'h0064},
        '{0, OFS_DUST, 32'h1}, '{0, OFS_OSIZE, 32'h0046},
        '{0, OFS_OSPEED, 32'h0640}, '{0, OFS_RESP, 32'h0050},
        '{0, OFS_FIELD, 32'h1}, '{0, 8'h20, 32'h0},
        '{1, 8'h20, 32'h5}, '{0, 8'h20, 32'h0},
        '{1, OFS_CTRL, 32'h3}, '{0, OFS_CTRL, 32'h0},
        '{1, OFS_DUST, 32'h0}, '{1, OFS_OSIZE, 32'h5},
        '{1, OFS_RESP, 32'h7}, '{0, OFS_OSIZE, 32'h5},
        '{1, OFS_CTRL, 32'h8}, '{0, OFS_DUST, 32'h1},
        '{0, OFS_OSIZE, 32'h0046}, '{0, OFS_RESP, 32'h0050},
        '{1, OFS_CTRL, 32'h0120}, '{0, OFS_RESP, 32'h00A0},
        '{0, OFS_FIELD, 32'hF}, '{1, OFS_CTRL, 32'h0130},
        '{0, OFS_OSIZE, 32'h0096}, '{0, OFS_FIELD, 32'h3},
        '{1, OFS_CTRL, 32'h0110}, '{0, OFS_RESP, 32'h0050},
        '{0, OFS_FIELD, 32'h1}, '{0, OFS_STATUS, 32'h4}
    };

    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        field_occupied;
    logic        near_field_occupied;
    logic        restart_btn;
    logic        switch_output_a;
    logic        switch_output_b;
    int          fails;
    int          samples_checked;

    ori_interlock #(.CYCLES_PER_MS(CPM), .BTN_LIMIT_MS(BLM)) uut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .field_occupied(field_occupied),
        .near_field_occupied(near_field_occupied),
        .restart_btn(restart_btn), .switch_output_a(switch_output_a),
        .switch_output_b(switch_output_b));
    ori_button_model btn (.clk(clk), .restart_btn(restart_btn));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic results();
        $display("counts: samples_checked=%0d fails=%0d",
                 samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // both outputs are compared as one pair
    task automatic chk_out(input logic exp);
        samples_checked++;
        if ({switch_output_a, switch_output_b} !== {2{exp}})
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time,
                     {switch_output_a, switch_output_b}, {2{exp}});
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_word(rdata, exp);
    endtask

    task automatic wait_out(input logic exp, input int bound);
        int k;
        for (k = 0; k < bound; k++)
        begin
            @(posedge clk);
            #1;
            if (switch_output_a === exp)
                break;
        end
        if (k == bound)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time,
                     switch_output_a, exp);
            results();
        end
        else
            chk_out(exp);
    endtask

    task automatic pulse_field(input int gap);
        @(posedge clk);
        field_occupied <= 1'b1;
        @(posedge clk);
        field_occupied <= 1'b0;
        #1 chk_out(1'b0);
        repeat (gap) @(posedge clk);
        #1 chk_out(1'b0);
    endtask

    task automatic do_reset(input logic [31:0] ctrl);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr_reg(OFS_CTRL, ctrl);
    endtask

    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        field_occupied = 1'b0;
        near_field_occupied = 1'b0;
        fails = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[i])
        begin
            if (ROWS[i].we)
                wr_reg(ROWS[i].a, ROWS[i].d);
            else
                rd_reg(ROWS[i].a, ROWS[i].d);
        end
        $display("test registers done");
        repeat (800) @(posedge clk);
        #1 chk_out(1'b0);
        wait_out(1'b1, 300);
        $display("test automatic start-up done");
        pulse_field(50);
        btn.press(2 * CPM);
        wait_out(1'b1, 8);
        pulse_field(5);
        btn.press((BLM + 5) * CPM);
        repeat (20) @(posedge clk);
        #1 chk_out(1'b0);
        btn.press(2 * CPM);
        wait_out(1'b1, 8);
        $display("test manual restart done");
        wr_reg(OFS_CTRL, 32'h0000_0004);
        wr_reg(OFS_DELAY, 32'h0000_0002);
        pulse_field(10);
        // taken again inside the delay: the delay must start over
        pulse_field(12);
        wait_out(1'b1, 20);
        $display("test automatic restart done");
        do_reset(32'h0000_0001);
        repeat (50) @(posedge clk);
        field_occupied <= 1'b1;
        #1 chk_out(1'b0);
        // a press while a field is occupied is refused
        btn.press(CPM);
        repeat (8) @(posedge clk);
        field_occupied <= 1'b0;
        #1 chk_out(1'b0);
        btn.press(CPM);
        wait_out(1'b1, 8);
        $display("test start interlock done");
        do_reset(32'h0000_0002);
        near_field_occupied <= 1'b1;
        repeat (1050) @(posedge clk);
        near_field_occupied <= 1'b0;
        #1 chk_out(1'b0);
        repeat (5) @(posedge clk);
        near_field_occupied <= 1'b1;
        #1 chk_out(1'b0);
        repeat (5) @(posedge clk);
        near_field_occupied <= 1'b0;
        #1 chk_out(1'b0);
        wait_out(1'b1, 8);
        $display("test start-up test done");
        results();
    end
endmodule
`default_nettype wire
